// File: inc/vlg_pkg.sv
// constants, register map and field layout of the video line gate
// Contract
// - blanking interrupt enable raises end-of-blanking interrupt
// - interrupt at earlier of V-drop or limit EAV
// - interrupt works regardless of crop setting
// - crop bit suppresses line-valid on blanking lines
// - only first N blanking lines get line-valid
// - only first N active lines get line-valid
// - read bit 30 gives field of interrupt EAV
// - read bit 31 gives blanking/active interrupt type
// - write bit 30 reserved, bit 31 translation enable
// - alias bit steers second misc address to control
// - control register resets to 0x80001
// - V and F sampled only at EAV
// - bit 19 holds translation module in reset
// - bit 0 disables translation path
package vlg_pkg;
  localparam int          ADR_W         = 8;
  localparam logic [7:0]  OFS_MISC_FIRST  = 8'h10;
  localparam logic [7:0]  OFS_MISC_SECOND = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h40;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h44;
  localparam int          MISC_ALIAS_BIT = 30;
  localparam int          CTL_DIS_BIT    = 0;
  localparam int          CTL_INT_BIT    = 1;
  localparam int          CTL_CROP_BIT   = 2;
  localparam int          CTL_VBI_LO     = 4;
  localparam int          CTL_VBI_W      = 5;
  localparam int          CTL_VID_LO     = 9;
  localparam int          CTL_VID_W      = 10;
  localparam int          CTL_RST_BIT    = 19;
  localparam int          CTL_FIELD_BIT  = 30;
  localparam int          CTL_TOP_BIT    = 31;
  localparam logic [31:0] CTL_RESET      = 32'h0008_0001;
  localparam int          EVT_W          = 2;
  localparam int          EVT_VBI_END    = 0;
  localparam int          EVT_FIELD      = 1;
  localparam logic [7:0]  CODE_FF        = 8'hFF;
  localparam logic [7:0]  CODE_00        = 8'h00;
  localparam int          CODE_F_BIT     = 6;
  localparam int          CODE_V_BIT     = 5;
  localparam int          CODE_H_BIT     = 4;
  typedef enum logic [1:0] {
    PRE_IDLE = 2'b00,
    PRE_FF   = 2'b01,
    PRE_00A  = 2'b10,
    PRE_00B  = 2'b11
  } vlg_pre_type;
endpackage : vlg_pkg

// File: core/vlg_line_gate.sv
// coded video stream to line-valid port translator with wishbone registers
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
module vlg_line_gate
  import vlg_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [vlg_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   vid_clk_i,
  input  wire logic [7:0]             vid_data_i,
  output logic      [7:0]             port_data_o,
  output logic                        port_line_valid_o,
  output logic                        port_intr_o,
  output logic                        irq_o
);
  import vlg_pkg::*;

  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdat;
    logic                 alias_sel;
    logic [31:0]          misc_second;
    logic                 dis;
    logic                 int_en;
    logic                 crop;
    logic [CTL_VBI_W-1:0] vbi_max;
    logic [CTL_VID_W-1:0] vid_max;
    logic                 mod_rst;
    logic                 xl_en;
    logic                 last_irq_field_bit;
    logic                 last_irq_was_blanking;
    logic [EVT_W-1:0]     sts;
    logic [EVT_W-1:0]     msk;
    logic                 irq;
    logic                 vs1;
    logic                 vs2;
    logic                 vs3;
    logic [7:0]           ds1;
    logic [7:0]           ds2;
    vlg_pre_type          pre;
    logic                 cur_v;
    logic                 cur_f;
    logic                 line_ok;
    logic                 arm;
    logic                 vact;
    logic [7:0]           vdat;
    logic [CTL_VBI_W-1:0] vbi_cnt;
    logic [CTL_VID_W-1:0] vid_cnt;
    logic                 fired;
    logic                 vintr;
  } vlg_state_type;

  vlg_state_type s_q;
  vlg_state_type s_d;

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [31:0]          ctl_word;
  logic [31:0]          ctl_read;
  logic [7:0]           adr_w;
  logic                 req;
  logic                 wr_now;
  logic                 run;
  logic                 edge_seen;
  logic [7:0]           b;
  logic                 nv;
  logic                 nf;
  logic [CTL_VBI_W-1:0] vbi_n;
  logic [CTL_VID_W-1:0] vid_n;
  logic [31:0]          w;
  logic [EVT_W-1:0]     evt;
  logic [EVT_W-1:0]     clr;

  always_comb begin
    // write view: bit 31 is the translation enable, bit 30 reserved
    ctl_word = '0;
    ctl_word[CTL_DIS_BIT]  = s_q.dis;
    ctl_word[CTL_INT_BIT]  = s_q.int_en;
    ctl_word[CTL_CROP_BIT] = s_q.crop;
    ctl_word[CTL_VBI_LO +: CTL_VBI_W] = s_q.vbi_max;
    ctl_word[CTL_VID_LO +: CTL_VID_W] = s_q.vid_max;
    ctl_word[CTL_RST_BIT]  = s_q.mod_rst;
    ctl_word[CTL_TOP_BIT]  = s_q.xl_en;
    ctl_read = ctl_word;
    ctl_read[CTL_FIELD_BIT] = s_q.last_irq_field_bit;
    ctl_read[CTL_TOP_BIT]   = s_q.last_irq_was_blanking;
  end

  always_comb begin
    s_d       = s_q;
    adr_w     = {wb_adr_i[7:2], 2'b00};
    req       = wb_cyc_i && wb_stb_i;
    wr_now    = req && wb_we_i && s_q.ack;
    run       = !s_q.dis && !s_q.mod_rst && s_q.xl_en;
    edge_seen = s_q.vs2 && !s_q.vs3;
    b         = s_q.ds2;
    nv        = b[CODE_V_BIT];
    nf        = b[CODE_F_BIT];
    vbi_n     = s_q.cur_v ? s_q.vbi_cnt : '0;
    vid_n     = s_q.cur_v ? '0 : s_q.vid_cnt;
    w         = '0;
    evt       = '0;
    clr       = '0;

    // bus slave: ack one cycle after request, write commits on the ack edge
    s_d.ack  = req && !s_q.ack;
    s_d.rdat = '0;
    if (req && !s_q.ack && !wb_we_i) begin
      unique case (adr_w)
        OFS_MISC_FIRST:  s_d.rdat = {1'b0, s_q.alias_sel, 30'h0000_0000};
        OFS_MISC_SECOND: s_d.rdat = s_q.alias_sel ? ctl_read : s_q.misc_second;
        OFS_IRQ_STATUS:  s_d.rdat = {30'h0000_0000, s_q.sts};
        OFS_IRQ_MASK:    s_d.rdat = {30'h0000_0000, s_q.msk};
        default:         s_d.rdat = '0;
      endcase
    end
    if (wr_now) begin
      unique case (adr_w)
        OFS_MISC_FIRST: begin
          w = merge({1'b0, s_q.alias_sel, 30'h0000_0000}, wb_dat_i, wb_sel_i);
          s_d.alias_sel = w[MISC_ALIAS_BIT];
        end
        OFS_MISC_SECOND: begin
          if (s_q.alias_sel) begin
            w = merge(ctl_word, wb_dat_i, wb_sel_i);
            s_d.dis     = w[CTL_DIS_BIT];
            s_d.int_en  = w[CTL_INT_BIT];
            s_d.crop    = w[CTL_CROP_BIT];
            s_d.vbi_max = w[CTL_VBI_LO +: CTL_VBI_W];
            s_d.vid_max = w[CTL_VID_LO +: CTL_VID_W];
            s_d.mod_rst = w[CTL_RST_BIT];
            s_d.xl_en   = w[CTL_TOP_BIT];
          end else begin
            s_d.misc_second = merge(s_q.misc_second, wb_dat_i, wb_sel_i);
          end
        end
        OFS_IRQ_STATUS: begin
          w   = merge('0, wb_dat_i, wb_sel_i);
          clr = w[EVT_W-1:0];
        end
        OFS_IRQ_MASK: begin
          w = merge({30'h0000_0000, s_q.msk}, wb_dat_i, wb_sel_i);
          s_d.msk = w[EVT_W-1:0];
        end
        default: ;
      endcase
    end

    // link clock and data: two flops each before use
    s_d.vs1 = vid_clk_i;
    s_d.vs2 = s_q.vs1;
    s_d.vs3 = s_q.vs2;
    s_d.ds1 = vid_data_i;
    s_d.ds2 = s_q.ds1;
    s_d.vintr = 1'b0;

    if (edge_seen) begin
      s_d.vdat = b;
      if (s_q.pre == PRE_00B) begin
        s_d.pre = PRE_IDLE;
        if (b[CODE_H_BIT]) begin
          // V and F change only here and apply to the next line
          s_d.cur_v = nv;
          s_d.cur_f = nf;
          s_d.vact  = 1'b0;
          if (nf != s_q.cur_f) begin
            evt[EVT_FIELD] = 1'b1;
          end
          // end of blanking: first non-V EAV or EAV of last counted line
          if (s_q.int_en && s_q.cur_v && !s_q.fired &&
              (!nv || s_q.vbi_cnt == s_q.vbi_max)) begin
            s_d.vintr = 1'b1;
            s_d.fired = 1'b1;
            s_d.last_irq_field_bit    = nf;
            s_d.last_irq_was_blanking = nv;
            evt[EVT_VBI_END] = 1'b1;
          end
          if (nv) begin
            if (!s_q.cur_v) begin
              s_d.fired = 1'b0;
            end
            s_d.line_ok = !s_q.crop && (vbi_n < s_q.vbi_max);
            s_d.vbi_cnt = (vbi_n < s_q.vbi_max) ? vbi_n + 1'b1 : vbi_n;
          end else begin
            s_d.line_ok = vid_n < s_q.vid_max;
            s_d.vid_cnt = (vid_n < s_q.vid_max) ? vid_n + 1'b1 : vid_n;
          end
        end else begin
          // start code only arms; valid waits for the first pixel byte
          s_d.arm = s_q.line_ok;
        end
      end else if (b == CODE_FF) begin
        // timing preamble ends the pixel period
        s_d.pre  = PRE_FF;
        s_d.vact = 1'b0;
        s_d.arm  = 1'b0;
      end else if (s_q.pre == PRE_FF && b == CODE_00) begin
        s_d.pre = PRE_00A;
      end else if (s_q.pre == PRE_00A && b == CODE_00) begin
        s_d.pre = PRE_00B;
      end else begin
        // pixel byte: valid only once the start code armed the line
        s_d.pre  = PRE_IDLE;
        s_d.vact = s_q.arm && run;
      end
    end

    // disable, module reset and enable, or crop on a blanking line, may change mid-line; drop valid at once
    if (!run || (s_q.crop && s_q.cur_v)) begin
      s_d.vact = 1'b0;
    end
    if (s_q.mod_rst) begin
      s_d.vact    = 1'b0;
      s_d.vintr   = 1'b0;
      s_d.vbi_cnt = '0;
      s_d.vid_cnt = '0;
      s_d.fired   = 1'b0;
      s_d.pre     = PRE_IDLE;
      s_d.line_ok = 1'b0;
      s_d.arm     = 1'b0;
      evt         = '0;
    end

    // a new event beats a simultaneous clear
    s_d.sts = (s_q.sts & ~clr) | evt;
    s_d.irq = |(s_q.sts & s_q.msk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q         <= '0;
      s_q.dis     <= CTL_RESET[CTL_DIS_BIT];
      s_q.mod_rst <= CTL_RESET[CTL_RST_BIT];
      s_q.xl_en   <= CTL_RESET[CTL_TOP_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o          = s_q.ack;
  assign wb_dat_o          = s_q.rdat;
  assign port_data_o       = s_q.vdat;
  assign port_line_valid_o = s_q.vact;
  assign port_intr_o       = s_q.vintr;
  assign irq_o             = s_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (s_q.ack |=> !s_q.ack)
    else $error("ack held longer than one cycle");
  crop_blank_a: assert property (s_q.crop && $past(s_q.crop) && s_q.cur_v |-> !s_q.vact)
    else $error("line valid on cropped blanking line");
  mod_reset_a: assert property (s_q.mod_rst |=> !s_q.vact && !s_q.vintr && s_q.vbi_cnt == '0)
    else $error("module reset did not quiet the path");
  disable_path_a: assert property (s_q.dis |=> !s_q.vact)
    else $error("line valid while disabled");
  intr_enable_a: assert property ($rose(s_q.vintr) |-> $past(s_q.int_en))
    else $error("port interrupt without enable");
  intr_pulse_a: assert property (s_q.vintr |=> !s_q.vintr ##1 !s_q.vintr)
    else $error("port interrupt not a single pulse");
  vbi_limit_a: assert property (s_q.vact && s_q.cur_v |-> s_q.vbi_cnt <= s_q.vbi_max)
    else $error("blanking line beyond limit passed");
  vid_limit_a: assert property (s_q.vact && !s_q.cur_v |-> s_q.vid_cnt <= s_q.vid_max)
    else $error("active line beyond limit passed");
  intr_field_a: assert property (s_q.vintr |->
                                 s_q.last_irq_field_bit == $past(s_q.ds2[CODE_F_BIT]))
    else $error("field bit not captured with interrupt");
  intr_type_a: assert property (s_q.vintr |->
                                s_q.last_irq_was_blanking == $past(s_q.ds2[CODE_V_BIT]))
    else $error("interrupt type not captured");
  reset_value_a: assert property ($past(rst_i) |-> ctl_word == CTL_RESET)
    else $error("control register reset value wrong");
  irq_level_a: assert property (s_q.irq |-> $past(|(s_q.sts & s_q.msk)))
    else $error("interrupt output without masked status");

  line_pass_c: cover property ($rose(s_q.vact) && !s_q.cur_v);
  intr_seen_c: cover property ($rose(s_q.vintr) && s_q.crop);
  alias_wr_c:  cover property (wr_now && adr_w == OFS_MISC_SECOND && s_q.alias_sel);
  vid_full_c:  cover property (s_q.vact && !s_q.cur_v && s_q.vid_cnt == s_q.vid_max);
  irq_clear_c: cover property (wr_now && adr_w == OFS_IRQ_STATUS && |s_q.sts);

  pixel_valid_a: assert property ($rose(s_q.vact) |-> $past(edge_seen && s_q.arm))
    else $error("line valid raised outside pixel period");
  vflag_eav_a: assert property ($changed(s_q.cur_v) |-> $past(s_q.pre == PRE_00B))
    else $error("line type changed away from a timing code");
endmodule : vlg_line_gate

// File: tb/vlg_vid_source.sv
// behavioural coded video source: link clock and byte stream
`timescale 1ns/10ps
module vlg_vid_source (
  output logic       vid_clk_o,
  output logic [7:0] vid_data_o
);
  initial begin
    vid_clk_o  = 1'b0;
    vid_data_o = 8'h00;
  end
  // data moves only while the link clock is low
  task automatic put(input logic [7:0] b);
    vid_data_o = b;
    #40 vid_clk_o = 1'b1;
    #40 vid_clk_o = 1'b0;
  endtask : put
  task automatic put_code(input logic [7:0] xy);
    for (int i = 0; i < 4; i++) begin
      put(i == 0 ? 8'hFF : (i == 3 ? xy : 8'h00));
    end
  endtask : put_code
  // one line: timing code, blanking bytes, start code, four pixels
  task automatic send_line(input logic v, input logic f);
    #3.7;
    put_code({1'b1, f, v, 1'b1, 4'h0});
    put(8'h10);
    put(8'h10);
    put_code({1'b1, f, v, 1'b0, 4'h0});
    for (int i = 0; i < 4; i++) begin
      put(8'h80 + 8'(i));
    end
    // clock stands still between lines; never leave a stale byte behind
    vid_data_o = ~vid_data_o;
  endtask : send_line
endmodule : vlg_vid_source

// File: tb/vlg_line_gate_tb.sv
// self-checking bench for the video line gate
`timescale 1ns/10ps
module vlg_line_gate_tb;
  import vlg_pkg::*;
  localparam logic [31:0] CFG = 32'h8000_0622;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] TOP = 32'hC000_0000;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        vid_clk;
  logic [7:0]  vid_data;
  logic [7:0]  port_data_o;
  logic        port_line_valid_o;
  logic        port_intr_o;
  logic        irq_o;
  logic        lv_prev;
  int          n_rise;
  int          n_intr;
  int          n_mismatch;
  int          check_count;

  vlg_line_gate i_vlg_line_gate (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .vid_clk_i(vid_clk), .vid_data_i(vid_data),
    .port_data_o(port_data_o), .port_line_valid_o(port_line_valid_o),
    .port_intr_o(port_intr_o), .irq_o(irq_o));
  vlg_vid_source i_vlg_vid_source (.vid_clk_o(vid_clk), .vid_data_o(vid_data));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // falling edge sampling keeps the monitor clear of the launch edge
  always @(negedge clk_i) begin
    if (port_line_valid_o === 1'b1 && lv_prev !== 1'b1) n_rise++;
    if (port_intr_o === 1'b1) n_intr++;
    lv_prev = port_line_valid_o;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask : rd

  task automatic lines(input logic v, input logic f, input int n);
    for (int i = 0; i < n; i++) begin
      i_vlg_vid_source.send_line(v, f);
      repeat (10) @(posedge clk_i);
    end
  endtask : lines

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // seventeen lines of about 1.2 us each; generous margin
  initial begin
    #100_000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    lv_prev = 1'b0;
    n_rise = 0;
    n_intr = 0;
    n_mismatch = 0;
    check_count = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_MISC_FIRST, ALL, 32'h0);
    wb(1'b1, OFS_MISC_FIRST, 32'h4000_0000);
    rd(OFS_MISC_FIRST, ALL, 32'h4000_0000);
    rd(OFS_MISC_SECOND, ALL, CTL_RESET);
    rd(8'h3C, ALL, 32'h0);
    wb(1'b1, OFS_MISC_SECOND, CFG | 32'h1);
    lines(1'b1, 1'b0, 3);
    lines(1'b0, 1'b0, 1);
    chk(n_rise, 0);
    chk(port_data_o, 8'h83);
    wb(1'b1, OFS_MISC_SECOND, CFG | 32'h0008_0000);
    n_intr = 0;
    lines(1'b1, 1'b0, 3);
    lines(1'b0, 1'b0, 1);
    chk(n_rise, 0);
    chk(n_intr, 0);
    wb(1'b1, OFS_IRQ_STATUS, 32'h3);
    wb(1'b1, OFS_IRQ_MASK, 32'h1);
    wb(1'b1, OFS_MISC_SECOND, CFG);
    lines(1'b1, 1'b0, 3);
    chk(n_rise, 2);
    chk(n_intr, 1);
    chk(irq_o, 1'b1);
    rd(OFS_MISC_SECOND, TOP, 32'h8000_0000);
    rd(OFS_IRQ_STATUS, ALL, 32'h1);
    wb(1'b1, OFS_IRQ_STATUS, 32'h1);
    rd(OFS_IRQ_STATUS, ALL, 32'h0);
    chk(irq_o, 1'b0);
    lines(1'b0, 1'b0, 4);
    chk(n_rise, 5);
    chk(n_intr, 1);
    wb(1'b1, OFS_MISC_SECOND, CFG | 32'h4);
    lines(1'b1, 1'b1, 1);
    lines(1'b0, 1'b1, 1);
    chk(n_rise, 6);
    chk(n_intr, 2);
    rd(OFS_MISC_SECOND, TOP, 32'h4000_0000);
    rd(OFS_IRQ_STATUS, ALL, 32'h3);
    wb(1'b1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    end_of_test;
  end
endmodule : vlg_line_gate_tb
